// >>> src/wst_sched.sv
// Top of the weekly sequence timer scheduler with register port and drive outputs
//
// Decided for this implementation: the strobed register port.
`default_nettype none
// Behaviour
// [RL1] Software keeps start within day, not after stop
// [RL2] Software keeps stop within day, not before start
// [RL3] Day code selects none, all, weekdays, weekend, single
// [RL4] Action selects output only, run, run without PI
// [RL5] Reference code selects presets, terminals, serial, option
// [RL6] Reference applies only for run actions
// [RL7] Input function 12/13 overrides timer run, newer firmware
// [RL8] Active on matching day, start inclusive, stop exclusive
module wst_sched
   import wst_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic [10:0] now_min,
   input  wire logic [2:0]  weekday,
   input  wire logic [7:0]  multifunction_input_function,
   input  wire logic        mfi_level,
   input  wire logic [15:0] firmware_version,
   output logic             t4_active,
   output logic             t4_dout,
   output logic             t3_dout,
   output logic             seq_run,
   output logic             seq_pi_off,
   output logic             seq_ref_valid,
   output logic      [2:0]  seq_ref_src
);
   // Configuration registers
   logic [10:0] t4_start_q, t4_start_d;       // Timer 4 start minute
   logic [10:0] t4_stop_q,  t4_stop_d;        // Timer 4 stop minute
   logic [3:0]  t4_day_q,   t4_day_d;         // Timer 4 day code
   logic [1:0]  t4_act_q,   t4_act_d;         // Timer 4 action
   logic [2:0]  t4_ref_q,   t4_ref_d;         // Timer 4 reference source
   logic [2:0]  t3_ref_q,   t3_ref_d;         // Timer 3 reference source
   logic        t3_on_q,    t3_on_d;          // Timer 3 active state, stand-in written over the register port
   logic [1:0]  t3_act_q,   t3_act_d;         // Timer 3 action
   logic [15:0] rdata_q,    rdata_d;          // Read data stage
   wst_res_t    out_q,      out_d;            // Registered drive outputs
   logic        t3dout_q,   t3dout_d;         // Timer 3 digital output
   wst_cfg_t    cfg4;                         // Timer 4 configuration carrier
   wst_res_t    res4;                         // Timer 4 evaluation
   logic        t3_run;                       // Timer 3 run request
   logic        override;                     // Input override active

   // Clamp a written time to the day range
   function automatic logic [10:0] clamp_time(input logic [15:0] v);
      return (v > {5'h00, WST_MIN_PER_DAY}) ? WST_MIN_PER_DAY : v[10:0];
   endfunction
   // Legal action code check, shared by both timers
   function automatic logic act_ok(input logic [15:0] v);
      return v <= {14'h0000, WST_ACT_RUN_NOPI};
   endfunction
   // Legal reference source check, shared by both timers
   function automatic logic ref_ok(input logic [15:0] v);
      return v <= {13'h0000, WST_REF_MAX};
   endfunction
   // Run decode of an action code
   function automatic logic is_run(input logic [1:0] a);
      return (a == WST_ACT_RUN) || (a == WST_ACT_RUN_NOPI);
   endfunction

   // Timer 4 evaluator
   assign cfg4 = '{start_min: t4_start_q, stop_min: t4_stop_q, day_sel: t4_day_q,
                   action: t4_act_q, ref_src: t4_ref_q};
   wst_eval u_eval4 (
      .now_min (now_min),
      .weekday (weekday),
      .cfg     (cfg4),
      .res     (res4)
   );

   // Register write next values
   always_comb begin
      t4_start_d = t4_start_q;
      t4_stop_d  = t4_stop_q;
      t4_day_d   = t4_day_q;
      t4_act_d   = t4_act_q;
      t4_ref_d   = t4_ref_q;
      t3_ref_d   = t3_ref_q;
      t3_on_d    = t3_on_q;
      t3_act_d   = t3_act_q;
      if (wr) begin
         case (addr)
            // Times kept in day range; order is software's duty
            WST_T4_START_ADDR: t4_start_d = clamp_time(wdata); // [RL1]
            WST_T4_STOP_ADDR:  t4_stop_d  = clamp_time(wdata); // [RL2]
            // Out of range codes are ignored
            WST_T4_DAY_ADDR: begin
               if (wdata <= {12'h000, WST_DAY_SUNDAY}) t4_day_d = wdata[3:0]; // [RL3]
            end
            WST_T4_ACT_ADDR: begin
               if (act_ok(wdata)) t4_act_d = wdata[1:0]; // [RL4]
            end
            WST_T4_REF_ADDR: begin
               if (ref_ok(wdata)) t4_ref_d = wdata[2:0]; // [RL5]
            end
            WST_T3_REF_ADDR: begin
               if (ref_ok(wdata)) t3_ref_d = wdata[2:0]; // [RL5]
            end
            // Timer 3 stand-in state and action
            WST_T3_STATE_ADDR: t3_on_d = wdata[0];
            WST_T3_ACT_ADDR: begin
               if (act_ok(wdata)) t3_act_d = wdata[1:0];
            end
            default: ;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t4_start_q <= WST_TIME_RST[10:0];
         t4_stop_q  <= WST_TIME_RST[10:0];
         t4_day_q   <= WST_DAY_RST[3:0];
         t4_act_q   <= WST_ACT_RST[1:0];
         t4_ref_q   <= WST_REF_RST[2:0];
         t3_ref_q   <= WST_REF_RST[2:0];
         t3_on_q    <= 1'b0;
         t3_act_q   <= WST_ACT_RST[1:0];
      end else begin
         t4_start_q <= t4_start_d;
         t4_stop_q  <= t4_stop_d;
         t4_day_q   <= t4_day_d;
         t4_act_q   <= t4_act_d;
         t4_ref_q   <= t4_ref_d;
         t3_ref_q   <= t3_ref_d;
         t3_on_q    <= t3_on_d;
         t3_act_q   <= t3_act_d;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 16'h0000;
      if (rd) begin
         case (addr)
            // Timer 4 settings
            WST_T4_START_ADDR: rdata_d = {5'h00, t4_start_q};
            WST_T4_STOP_ADDR:  rdata_d = {5'h00, t4_stop_q};
            WST_T4_DAY_ADDR:   rdata_d = {12'h000, t4_day_q};
            WST_T4_ACT_ADDR:   rdata_d = {14'h0000, t4_act_q};
            WST_T4_REF_ADDR:   rdata_d = {13'h0000, t4_ref_q};
            // Timer 3 settings and stand-in state
            WST_T3_REF_ADDR:   rdata_d = {13'h0000, t3_ref_q};
            WST_T3_STATE_ADDR: rdata_d = {15'h0000, t3_on_q};
            WST_T3_ACT_ADDR:   rdata_d = {14'h0000, t3_act_q};
            // Live status of the registered outputs
            WST_STATUS_ADDR:   rdata_d = {10'h000, out_q.ref_src, out_q.pi_off,
                                          out_q.run, out_q.active};
            default:           rdata_d = 16'h0000;
         endcase
      end
   end

   // Arbitration of timer run requests and reference selection
   always_comb begin
      // Input function 12 or 13 wins over the timer run on newer firmware
      override = mfi_level && (firmware_version >= WST_FW_MIN_VER)
                 && (multifunction_input_function == WST_MFI_FN_A
                     || multifunction_input_function == WST_MFI_FN_B); // [RL7]
      t3_run   = t3_on_q && is_run(t3_act_q);
      t3dout_d = t3_on_q;
      out_d         = res4;
      out_d.run     = (res4.run || t3_run) && !override; // [RL7]
      out_d.pi_off  = out_d.run && (res4.pi_off || (t3_run && t3_act_q == WST_ACT_RUN_NOPI));
      // Reference applies only with run actions; timer 4 has precedence
      out_d.ref_valid = out_d.run; // [RL6]
      if (res4.run) begin
         out_d.ref_src = t4_ref_q; // [RL6]
      end else if (t3_run) begin
         out_d.ref_src = t3_ref_q; // [RL6]
      end else begin
         out_d.ref_src = 3'h0;
      end
   end

   // Output registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= 16'h0000;
         out_q    <= '0;
         t3dout_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         out_q    <= out_d;
         t3dout_q <= t3dout_d;
      end
   end

   assign rdata         = rdata_q;
   assign t4_active     = out_q.active;
   assign t4_dout       = out_q.dout;
   assign t3_dout       = t3dout_q;
   assign seq_run       = out_q.run;
   assign seq_pi_off    = out_q.pi_off;
   assign seq_ref_valid = out_q.ref_valid;
   assign seq_ref_src   = out_q.ref_src;

   // Named steps shared by the properties below
   // A legal day code written to timer 4
   sequence s_day_write;
      wr && (addr == WST_T4_DAY_ADDR) && (wdata <= {12'h000, WST_DAY_SUNDAY});
   endsequence
   // A legal action code written to timer 4
   sequence s_act_write;
      wr && (addr == WST_T4_ACT_ADDR) && (wdata <= {14'h0000, WST_ACT_RUN_NOPI});
   endsequence
   // A legal reference code written to timer 4
   sequence s_ref_write;
      wr && (addr == WST_T4_REF_ADDR) && (wdata <= {13'h0000, WST_REF_MAX});
   endsequence
   // An in-range start time written to timer 4
   sequence s_start_write;
      wr && (addr == WST_T4_START_ADDR) && (wdata <= {5'h00, WST_MIN_PER_DAY});
   endsequence
   // An in-range stop time written to timer 4
   sequence s_stop_write;
      wr && (addr == WST_T4_STOP_ADDR) && (wdata <= {5'h00, WST_MIN_PER_DAY});
   endsequence
   // Timer 4 runs and no input holds it off
   sequence s_t4_runs;
      res4.run && !override;
   endsequence
   // Only timer 3 runs and no input holds it off
   sequence s_t3_alone;
      t3_run && !res4.run && !override;
   endsequence
   // Neither timer asks for a run
   sequence s_none_runs;
      !res4.run && !t3_run;
   endsequence

   // Reference valid only with a run action
   a_ref_gate: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
      seq_ref_valid |-> seq_run) else $error("reference valid without run");
   // Action zero on timer 4 alone never runs
   a_dout_norun: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      (t4_act_q == WST_ACT_DOUT && !t3_on_q) |=> !seq_run)
      else $error("run with digital-output action");
   // Override suppresses run
   a_mfi_override: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
      override |=> !seq_run) else $error("override did not stop run");
   // Override also withdraws the reference selection
   a_override_ref: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
      override |=> !seq_ref_valid) else $error("reference kept under override");
   // Disabled day code never activates
   a_day_off: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
      (t4_day_q == WST_DAY_OFF) |=> !t4_active) else $error("disabled timer active");
   // Window bounds
   a_active_window: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
      (now_min < t4_start_q || now_min >= t4_stop_q) |=> !t4_active)
      else $error("active outside window");
   // Active timer asks for its digital output whatever the action
   a_dout_follow: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      res4.active |=> t4_dout) else $error("digital output missing while active");
   // Active timer with a run action commands a run unless held off
   a_run_action: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      (res4.active && t4_act_q != WST_ACT_DOUT && !override) |=> seq_run)
      else $error("run missing while active");
   // Timer 4 reference takes effect when it runs
   a_ref_src: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
      s_t4_runs |=> (seq_ref_src == $past(t4_ref_q)))
      else $error("wrong reference source");
   // Timer 3 reference takes effect when it runs alone
   a_t3_ref: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
      s_t3_alone |=> (seq_ref_src == $past(t3_ref_q)))
      else $error("timer 3 reference not applied");
   // Without a run action the reference selection does not apply
   a_no_ref: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
      s_none_runs |=> !seq_ref_valid) else $error("reference valid without run action");
   // Times never exceed one day
   a_time_range: assert property (@(posedge clk) disable iff (!rst_n) // [RL1] [RL2]
      t4_start_q <= WST_MIN_PER_DAY && t4_stop_q <= WST_MIN_PER_DAY)
      else $error("time out of range");
   // Legal codes and times are stored at the next edge
   a_day_store: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
      s_day_write |=> (t4_day_q == $past(wdata[3:0])))
      else $error("legal day code not stored");
   a_act_store: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      s_act_write |=> (t4_act_q == $past(wdata[1:0])))
      else $error("legal action code not stored");
   a_ref_store: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
      s_ref_write |=> (t4_ref_q == $past(wdata[2:0])))
      else $error("legal reference code not stored");
   a_start_store: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
      s_start_write |=> (t4_start_q == $past(wdata[10:0])))
      else $error("start time not stored");
   a_stop_store: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
      s_stop_write |=> (t4_stop_q == $past(wdata[10:0])))
      else $error("stop time not stored");
   // PI disable only with a run
   a_pi_off: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      seq_pi_off |-> seq_run) else $error("pi disable without run");
   // Timer 3 digital output follows its state one edge later
   a_t3_dout: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      t3_on_q |=> t3_dout) else $error("timer 3 digital output missing");
endmodule
`default_nettype wire

// >>> inc/wst_pkg.sv
// Package: register map, field codes and carrier types of the weekly sequence timer scheduler
`default_nettype none
package wst_pkg;
   // Register indices as they appear on the plain register port
   localparam logic [15:0] WST_T3_REF_ADDR    = 16'h3214;
   localparam logic [15:0] WST_T4_START_ADDR  = 16'h3215;
   localparam logic [15:0] WST_T4_STOP_ADDR   = 16'h3216;
   localparam logic [15:0] WST_T4_DAY_ADDR    = 16'h3217;
   localparam logic [15:0] WST_T4_ACT_ADDR    = 16'h3218;
   localparam logic [15:0] WST_T4_REF_ADDR    = 16'h3219;
   localparam logic [15:0] WST_T3_STATE_ADDR  = 16'h3280;
   localparam logic [15:0] WST_T3_ACT_ADDR    = 16'h3281;
   localparam logic [15:0] WST_STATUS_ADDR    = 16'h3282;
   // Reset values
   localparam logic [15:0] WST_REF_RST        = 16'h0000;
   localparam logic [15:0] WST_TIME_RST       = 16'h0000;
   localparam logic [15:0] WST_DAY_RST        = 16'h0000;
   localparam logic [15:0] WST_ACT_RST        = 16'h0000;
   // Time of day in minutes, 24:00 is 1440
   localparam logic [10:0] WST_MIN_PER_DAY    = 11'h5A0;
   // Day selection codes
   localparam logic [3:0]  WST_DAY_OFF        = 4'h0;
   localparam logic [3:0]  WST_DAY_DAILY      = 4'h1;
   localparam logic [3:0]  WST_DAY_WEEKDAYS   = 4'h2;
   localparam logic [3:0]  WST_DAY_WEEKEND    = 4'h3;
   localparam logic [3:0]  WST_DAY_MONDAY     = 4'h4;
   localparam logic [3:0]  WST_DAY_SUNDAY     = 4'hA;
   // Weekday encoding of the calendar: 0 Monday .. 6 Sunday
   localparam logic [2:0]  WST_WD_SATURDAY    = 3'h5;
   // Action codes
   localparam logic [1:0]  WST_ACT_DOUT       = 2'h0;
   localparam logic [1:0]  WST_ACT_RUN        = 2'h1;
   localparam logic [1:0]  WST_ACT_RUN_NOPI   = 2'h2;
   // Reference source top code
   localparam logic [2:0]  WST_REF_MAX        = 3'h6;
   // Multifunction input override function codes
   localparam logic [7:0]  WST_MFI_FN_A       = 8'h0C;
   localparam logic [7:0]  WST_MFI_FN_B       = 8'h0D;
   localparam logic [15:0] WST_FW_MIN_VER     = 16'h03FA;

   // Timer configuration carrier
   typedef struct packed {
      logic [10:0] start_min;   // Start time in minutes
      logic [10:0] stop_min;    // Stop time in minutes
      logic [3:0]  day_sel;     // Day selection code
      logic [1:0]  action;      // Action code
      logic [2:0]  ref_src;     // Reference source code
   } wst_cfg_t;

   // Evaluation result carrier
   typedef struct packed {
      logic       active;       // Timer window and day match
      logic       dout;         // Digital output request
      logic       run;          // Run request
      logic       pi_off;       // PI disable request
      logic       ref_valid;    // Reference selection applies
      logic [2:0] ref_src;      // Selected reference source
   } wst_res_t;
endpackage
`default_nettype wire

// >>> src/wst_eval.sv
// Combinational evaluator of one sequence timer against the calendar
`default_nettype none
module wst_eval
   import wst_pkg::*;
(
   input  wire logic [10:0] now_min,
   input  wire logic [2:0]  weekday,
   input  wire wst_cfg_t    cfg,
   output var wst_res_t     res
);
   // Day match decode
   function automatic logic day_match(input logic [3:0] sel, input logic [2:0] wd);
      logic m;
      m = 1'b0;
      case (sel)
         WST_DAY_OFF:      m = 1'b0;
         WST_DAY_DAILY:    m = 1'b1;
         WST_DAY_WEEKDAYS: m = (wd < WST_WD_SATURDAY);
         WST_DAY_WEEKEND:  m = (wd >= WST_WD_SATURDAY) && (wd <= 3'h6);
         default: begin
            // Single day codes, Monday upward
            if (sel >= WST_DAY_MONDAY && sel <= WST_DAY_SUNDAY) begin
               m = ({1'b0, wd} == 4'(sel - WST_DAY_MONDAY));
            end else begin
               m = 1'b0;
            end
         end
      endcase
      return m;
   endfunction

   logic act; // Active window
   always_comb begin
      // Active when day matches and start <= now < stop
      act = day_match(cfg.day_sel, weekday) && (now_min >= cfg.start_min)
            && (now_min < cfg.stop_min); // [RL8] [RL3]
      res.active    = act;
      res.dout      = act; // [RL4]
      res.run       = act && (cfg.action == WST_ACT_RUN || cfg.action == WST_ACT_RUN_NOPI);
      res.pi_off    = act && (cfg.action == WST_ACT_RUN_NOPI); // [RL4]
      res.ref_valid = res.run; // [RL6]
      res.ref_src   = cfg.ref_src; // [RL5]
   end
endmodule
`default_nettype wire

// >>> verif/wst_drive_model.sv
// Behavioural drive sequencer fed by the scheduler's run and reference requests
`default_nettype none
module wst_drive_model
   import wst_pkg::*;
#(
   parameter logic [2:0] LOCAL_REF = 3'h4  // Source used when no timer reference applies
)(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       seq_run,
   input  wire logic       seq_ref_valid,
   input  wire logic [2:0] seq_ref_src,
   output logic            running,
   output logic      [2:0] ref_used
);
   timeunit 1ns;
   timeprecision 100ps;
   // Follow the run request; a timer source replaces the local one only when flagged valid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         running  <= 1'b0;
         ref_used <= LOCAL_REF;
      end else begin
         running  <= seq_run;
         ref_used <= seq_ref_valid ? seq_ref_src : LOCAL_REF;
      end
   end
endmodule
`default_nettype wire

// >>> verif/wst_sched_test.sv
// Self-checking testbench of the weekly sequence timer scheduler
`default_nettype none
module wst_sched_test;
   import wst_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, wr, rd, mfi_level;     // Clock, reset, strobes, input level
   logic [15:0] addr, wdata, fw;                  // Register port and firmware version
   logic [10:0] now_min;                          // Time of day in minutes
   logic [2:0]  weekday;                          // 0 Monday .. 6 Sunday
   logic [7:0]  mfi_fn;                           // Configured input function
   wire  [15:0] rdata;                            // Read data
   wire  [2:0]  seq_ref_src, ref_used;            // Selected and applied sources
   wire         t4_active, t4_dout, t3_dout, seq_run, seq_pi_off, seq_ref_valid, running;
   int          n_errors, comparisons;            // Mismatch and comparison counters

   wst_sched DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .now_min(now_min), .weekday(weekday),
      .multifunction_input_function(mfi_fn), .mfi_level(mfi_level),
      .firmware_version(fw), .t4_active(t4_active), .t4_dout(t4_dout), .t3_dout(t3_dout),
      .seq_run(seq_run), .seq_pi_off(seq_pi_off), .seq_ref_valid(seq_ref_valid),
      .seq_ref_src(seq_ref_src));
   wst_drive_model drv (.clk(clk), .rst_n(rst_n), .seq_run(seq_run),
      .seq_ref_valid(seq_ref_valid), .seq_ref_src(seq_ref_src), .running(running),
      .ref_used(ref_used));

   // Free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compare a register-sized value
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare a single flag
   task automatic check_flag(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask
   // One-cycle write on the register port
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle read; data is taken in the following cycle only
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Let config and level inputs reach the registered outputs
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Expected day match for a code and a weekday
   function automatic logic day_hit(input int d, input int w);
      return (d == 1) || (d == 2 && w < 5) || (d == 3 && w >= 5) || (d >= 4 && w == d - 4);
   endfunction

   // Reset values of the six registers at 3214..3219 and a read of an unmapped index
   task automatic t_reset;
      logic [15:0] v;
      for (int i = 0; i < 6; i++) begin
         rd_reg(WST_T3_REF_ADDR + 16'(i), v);
         check(v, 16'h0000);
      end
      rd_reg(16'h3300, v);
      check(v, 16'h0000);
      $display("test reset done");
   endtask
   // Every day code against every weekday, full-day window
   task automatic t_days;
      wr_reg(WST_T4_START_ADDR, 16'h0000);
      wr_reg(WST_T4_STOP_ADDR, 16'h05A0);
      now_min <= 11'h258;
      for (int d = 0; d <= 10; d++) begin
         wr_reg(WST_T4_DAY_ADDR, 16'(d));
         for (int w = 0; w < 7; w++) begin
            weekday <= 3'(w);
            settle();
            check_flag(t4_active, day_hit(d, w));
            check_flag(t4_dout, day_hit(d, w));
         end
      end
      $display("test days done");
   endtask
   // Start inclusive, stop exclusive, equal bounds never active
   task automatic t_window;
      int tm[5] = '{479, 480, 599, 600, 600};
      logic ex[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      wr_reg(WST_T4_DAY_ADDR, 16'h0001);
      wr_reg(WST_T4_START_ADDR, 16'h01E0);
      wr_reg(WST_T4_STOP_ADDR, 16'h0258);
      for (int i = 0; i < 5; i++) begin
         if (i == 4) wr_reg(WST_T4_START_ADDR, 16'h0258);
         now_min <= 11'(tm[i]);
         settle();
         check_flag(t4_active, ex[i]);
      end
      wr_reg(WST_T4_START_ADDR, 16'h01E0);
      now_min <= 11'h1F4;
      $display("test window done");
   endtask
   // Every action with every reference source while active
   task automatic t_action;
      for (int a = 0; a < 3; a++) begin
         for (int r = 0; r < 7; r++) begin
            wr_reg(WST_T4_ACT_ADDR, 16'(a));
            wr_reg(WST_T4_REF_ADDR, 16'(r));
            settle();
            check_flag(seq_run, a != 0);
            check_flag(running, a != 0);
            check_flag(seq_pi_off, a == 2);
            check_flag(seq_ref_valid, a != 0);
            if (a != 0) check(16'(seq_ref_src), 16'(r));
            check(16'(ref_used), a != 0 ? 16'(r) : 16'h0004);
         end
      end
      $display("test action done");
   endtask
   // Input function 12/13 overrides the run on newer firmware only
   task automatic t_override;
      logic [7:0] fn[5] = '{8'h0C, 8'h0D, 8'h0D, 8'h0B, 8'h0C};
      logic lv[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      logic [15:0] fv[5] = '{16'h03FA, 16'h03FB, 16'h03F9, 16'h03FA, 16'h03FA};
      logic ex[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      wr_reg(WST_T4_ACT_ADDR, 16'h0001);
      for (int i = 0; i < 5; i++) begin
         mfi_fn    <= fn[i];
         mfi_level <= lv[i];
         fw        <= fv[i];
         settle();
         check_flag(seq_run, ex[i]);
      end
      mfi_level <= 1'b0;
      $display("test override done");
   endtask
   // Out-of-range codes leave the stored value untouched
   task automatic t_refuse;
      logic [15:0] v;
      wr_reg(WST_T4_DAY_ADDR, 16'h000A);
      wr_reg(WST_T4_DAY_ADDR, 16'h000B);
      rd_reg(WST_T4_DAY_ADDR, v);
      check(v, 16'h000A);
      wr_reg(WST_T4_ACT_ADDR, 16'h0003);
      rd_reg(WST_T4_ACT_ADDR, v);
      check(v, 16'h0001);
      wr_reg(WST_T3_REF_ADDR, 16'h0006);
      wr_reg(WST_T3_REF_ADDR, 16'h0007);
      rd_reg(WST_T3_REF_ADDR, v);
      check(v, 16'h0006);
      $display("test refuse done");
   endtask
   // Timer 3 run path, its reference source and the precedence of timer 4
   task automatic t_timer3;
      logic [15:0] v;
      wr_reg(WST_T4_ACT_ADDR, 16'h0000);
      wr_reg(WST_T3_REF_ADDR, 16'h0005);
      wr_reg(WST_T3_ACT_ADDR, 16'h0002);
      wr_reg(WST_T3_STATE_ADDR, 16'h0001);
      settle();
      check_flag(t3_dout, 1'b1);
      check_flag(seq_run, 1'b1);
      check_flag(seq_pi_off, 1'b1);
      check(16'(seq_ref_src), 16'h0005);
      check(16'(ref_used), 16'h0005);
      rd_reg(WST_STATUS_ADDR, v);
      check(v, 16'h002F);
      wr_reg(WST_T4_REF_ADDR, 16'h0003);
      wr_reg(WST_T4_ACT_ADDR, 16'h0001);
      settle();
      check(16'(seq_ref_src), 16'h0003);
      wr_reg(WST_T4_ACT_ADDR, 16'h0000);
      wr_reg(WST_T3_ACT_ADDR, 16'h0000);
      settle();
      check_flag(seq_run, 1'b0);
      check_flag(seq_ref_valid, 1'b0);
      check(16'(ref_used), 16'h0004);
      wr_reg(WST_T3_STATE_ADDR, 16'h0000);
      settle();
      check_flag(t3_dout, 1'b0);
      $display("test timer3 done");
   endtask
   // Reset in mid-run clears the settings and the registered outputs
   task automatic t_rereset;
      logic [15:0] v;
      wr_reg(WST_T4_ACT_ADDR, 16'h0001);
      wr_reg(WST_T3_STATE_ADDR, 16'h0001);
      settle();
      check_flag(seq_run, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check_flag(seq_run, 1'b0);
      check_flag(t3_dout, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(WST_T4_DAY_ADDR, v);
      check(v, 16'h0000);
      rd_reg(WST_T4_ACT_ADDR, v);
      check(v, 16'h0000);
      rd_reg(WST_T3_REF_ADDR, v);
      check(v, 16'h0000);
      check_flag(t4_active, 1'b0);
      $display("test rereset done");
   endtask

   // Print the counts and the verdict, then stop
   task automatic results;
      $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence: reset for six cycles, then every scenario
   initial begin
      {rst_n, wr, rd, mfi_level} = 4'h0;
      {addr, wdata, fw} = '0;
      now_min = 11'h000;
      weekday = 3'h0;
      mfi_fn = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_days();
      t_window();
      t_action();
      t_override();
      t_refuse();
      t_timer3();
      t_rereset();
      results();
   end
   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #200000;
      n_errors++;
      results();
   end
endmodule
`default_nettype wire
